//--- rtl/tom_trigger_engine.sv
// Trigger combination engine: OR and AND masks, enable, force, delay
// Operation
// - Board trigger from AND mask and OR mask
// - Global enable gates every trigger source
// - Force command starts the delay at once while waiting, enable or not
// - Combined event passes programmable delay first
// - Only sources with set mask bits count
// - Sources encoded one per bit, combinable
// - Zero selects none; bit 0 software trigger
// - Bit 1 enables external input 0
// - Bit 2 enables external input 1, digital only
// - Bits 8, 9 enable extra TTL inputs
// - General availability mask shows existing sources
// - General OR mask resets to software source
// - Low channel word selects channels 0 to 31
// - High channel word selects channels 32 to 63
// - Channel availability words report usable channels
// - Channel sources exist on acquisition variants only
// - Analog one external input, digital one or two
`timescale 1ns/10ps
`default_nettype none

module tom_trigger_engine #(
    parameter bit ACQUISITION   = 1'b1,
    parameter bit DIGITAL       = 1'b0,
    parameter bit HAS_EXT1      = 1'b0,
    parameter bit HAS_EXTRA_IO  = 1'b0,
    parameter int NUM_CHANNELS  = 64
) (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_rd_in,
    input  wire logic        ext_trigger_in0,
    input  wire logic        ext_trigger_in1,
    input  wire logic        extra_trigger_in0,
    input  wire logic        extra_trigger_in1,
    input  wire logic [63:0] channel_trig_in,
    output logic [31:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic             trigger_out,
    output logic             or_hit_out,
    output logic             waiting_out
);

    // ========================================================
    // Availability, fixed by the fitted options
    function automatic logic [31:0] gen_avail();
        logic [31:0] m;
        m = tom_pkg::NO_SOURCE;
        m[tom_pkg::SOFT_POS]  = 1'b1;
        m[tom_pkg::EXT0_POS]  = 1'b1;
        m[tom_pkg::EXT1_POS]  = DIGITAL && HAS_EXT1;
        m[tom_pkg::XTTL0_POS] = HAS_EXTRA_IO;
        m[tom_pkg::XTTL1_POS] = HAS_EXTRA_IO;
        return m;
    endfunction

    function automatic logic [63:0] ch_avail();
        logic [63:0] m;
        m = 64'h0;
        for (int i = 0; i < 64; i++) begin
            m[i] = ACQUISITION && (i < NUM_CHANNELS);
        end
        return m;
    endfunction

    localparam logic [31:0] GEN_AVAIL = gen_avail();
    localparam logic [63:0] CH_AVAIL  = ch_avail();

    // ========================================================
    // Pin synchronisers
    logic [tom_pkg::NUM_PINS-1:0] pin_raw;
    logic [tom_pkg::NUM_PINS-1:0] pin_meta;
    logic [tom_pkg::NUM_PINS-1:0] pin_sync;

    assign pin_raw = {extra_trigger_in1, extra_trigger_in0,
                      ext_trigger_in1, ext_trigger_in0};

    genvar g;
    generate
        for (g = 0; g < tom_pkg::NUM_PINS; g++) begin : g_sync
            always_ff @(posedge clk_sys_in) begin
                if (reset_in) begin
                    pin_meta[g] <= 1'b0;
                    pin_sync[g] <= 1'b0;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    // ========================================================
    // Registers
    logic [31:0]         gen_or_select;
    logic [31:0]         gen_and_select;
    logic [63:0]         ch_or_select;
    logic [63:0]         ch_and_select;
    logic [31:0]         delay_value;
    logic                trig_enable;
    logic                fired;
    tom_pkg::tom_state_t state;
    logic [31:0]         delay_cnt;

    logic wr_start;
    logic wr_force;
    logic wr_stop;

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] idx);
        return a == idx;
    endfunction

    // Unavailable bits are dropped on write so they read back zero
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            gen_or_select  <= tom_pkg::GEN_OR_RESET;
            gen_and_select <= tom_pkg::GEN_AND_RESET;
            ch_or_select   <= {2{tom_pkg::CH_MASK_RESET}};
            ch_and_select  <= {2{tom_pkg::CH_MASK_RESET}};
            delay_value    <= tom_pkg::DELAY_RESET;
            trig_enable    <= 1'b0;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, tom_pkg::GEN_OR_SELECT_IDX)) begin
                gen_or_select <= reg_wdata_in & GEN_AVAIL;
            end
            if (hit(reg_addr_in, tom_pkg::GEN_AND_SELECT_IDX)) begin
                // Software trigger has no place in the AND mask
                gen_and_select <= reg_wdata_in & GEN_AVAIL
                                & ~tom_pkg::SOFT_SOURCE;
            end
            if (hit(reg_addr_in, tom_pkg::CH_OR_SEL_LO_IDX)) begin
                ch_or_select[31:0] <= reg_wdata_in
                                    & CH_AVAIL[31:0];
            end
            if (hit(reg_addr_in, tom_pkg::CH_OR_SEL_HI_IDX)) begin
                ch_or_select[63:32] <= reg_wdata_in
                                     & CH_AVAIL[63:32];
            end
            if (hit(reg_addr_in, tom_pkg::CH_AND_SEL_LO_IDX)) begin
                ch_and_select[31:0] <= reg_wdata_in & CH_AVAIL[31:0];
            end
            if (hit(reg_addr_in, tom_pkg::CH_AND_SEL_HI_IDX)) begin
                ch_and_select[63:32] <= reg_wdata_in & CH_AVAIL[63:32];
            end
            if (hit(reg_addr_in, tom_pkg::DELAY_IDX)) begin
                delay_value <= reg_wdata_in;
            end
            if (hit(reg_addr_in, tom_pkg::CONTROL_IDX)) begin
                trig_enable <= reg_wdata_in[tom_pkg::CTL_ENABLE_POS];
            end
        end
    end

    assign wr_start = reg_wr_in && hit(reg_addr_in, tom_pkg::CONTROL_IDX)
                    && reg_wdata_in[tom_pkg::CTL_START_POS];
    assign wr_force = reg_wr_in && hit(reg_addr_in, tom_pkg::CONTROL_IDX)
                    && reg_wdata_in[tom_pkg::CTL_FORCE_POS];
    assign wr_stop  = reg_wr_in && hit(reg_addr_in, tom_pkg::CONTROL_IDX)
                    && reg_wdata_in[tom_pkg::CTL_STOP_POS];

    // ========================================================
    // Source combination
    logic [31:0] gen_events;
    logic        waiting;
    logic        or_event;
    logic        and_event;
    logic        and_armed;
    logic        combined;

    assign waiting = (state == tom_pkg::TOM_WAIT);

    always_comb begin
        gen_events = tom_pkg::NO_SOURCE;
        // Software source is true for as long as the board waits
        gen_events[tom_pkg::SOFT_POS]  = waiting;
        gen_events[tom_pkg::EXT0_POS]  = pin_sync[0];
        gen_events[tom_pkg::EXT1_POS]  = pin_sync[1];
        gen_events[tom_pkg::XTTL0_POS] = pin_sync[2];
        gen_events[tom_pkg::XTTL1_POS] = pin_sync[3];
    end

    // Masks already hold only available bits
    assign or_event = |(gen_events & gen_or_select)
                    | |(channel_trig_in & ch_or_select);

    // An empty AND mask must not fire on its own
    assign and_armed = (gen_and_select != tom_pkg::NO_SOURCE)
                     || (ch_and_select != 64'h0);
    assign and_event = and_armed
                     && ((gen_events & gen_and_select) == gen_and_select)
                     && ((channel_trig_in & ch_and_select)
                         == ch_and_select);

    assign combined = trig_enable
                    && (or_event || and_event);

    // ========================================================
    // Sequencer and delay
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state     <= tom_pkg::TOM_IDLE;
            delay_cnt <= 32'h0;
            fired     <= 1'b0;
        end else if (wr_stop) begin
            state     <= tom_pkg::TOM_IDLE;
        end else begin
            case (state)
                tom_pkg::TOM_IDLE: begin
                    if (wr_start) begin
                        state <= tom_pkg::TOM_WAIT;
                        fired <= 1'b0;
                    end
                end
                tom_pkg::TOM_WAIT: begin
                    if (combined || wr_force) begin
                        state     <= tom_pkg::TOM_DELAY;
                        delay_cnt <= delay_value;
                    end
                end
                tom_pkg::TOM_DELAY: begin
                    if (delay_cnt == 32'h0) begin
                        state <= tom_pkg::TOM_IDLE;
                        fired <= 1'b1;
                    end else begin
                        delay_cnt <= delay_cnt - 32'h1;
                    end
                end
                default: begin
                    state <= tom_pkg::TOM_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Outputs
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            trigger_out <= 1'b0;
            or_hit_out  <= 1'b0;
            waiting_out <= 1'b0;
        end else begin
            trigger_out <= (state == tom_pkg::TOM_DELAY)
                        && (delay_cnt == 32'h0) && !wr_stop;
            or_hit_out  <= trig_enable && or_event;
            waiting_out <= waiting;
        end
    end

    // ========================================================
    // Read-back
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0;
        case (reg_addr_in)
            tom_pkg::GEN_OR_AVAIL_IDX:   next_rdata = GEN_AVAIL;
            tom_pkg::GEN_OR_SELECT_IDX:  next_rdata = gen_or_select;
            tom_pkg::GEN_AND_SELECT_IDX: next_rdata = gen_and_select;
            tom_pkg::CH_OR_AVAIL_LO_IDX: next_rdata = CH_AVAIL[31:0];
            tom_pkg::CH_OR_AVAIL_HI_IDX: next_rdata = CH_AVAIL[63:32];
            tom_pkg::CH_OR_SEL_LO_IDX:   next_rdata = ch_or_select[31:0];
            tom_pkg::CH_OR_SEL_HI_IDX:   next_rdata = ch_or_select[63:32];
            tom_pkg::CH_AND_SEL_LO_IDX:  next_rdata = ch_and_select[31:0];
            tom_pkg::CH_AND_SEL_HI_IDX:  next_rdata = ch_and_select[63:32];
            tom_pkg::DELAY_IDX:          next_rdata = delay_value;
            tom_pkg::CONTROL_IDX: begin
                next_rdata[tom_pkg::CTL_ENABLE_POS] = trig_enable;
            end
            tom_pkg::STATUS_IDX: begin
                next_rdata[tom_pkg::ST_WAIT_POS]  = waiting;
                next_rdata[tom_pkg::ST_DELAY_POS] =
                    (state == tom_pkg::TOM_DELAY);
                next_rdata[tom_pkg::ST_FIRED_POS] = fired;
            end
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            reg_rdata_out  <= 32'h0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

endmodule

`default_nettype wire

//--- rtl/tom_pkg.sv
// Constants for the trigger OR mask engine
package tom_pkg;

    // ========================================================
    // Register indices
    localparam logic [15:0] GEN_OR_AVAIL_IDX   = 16'h9dd0;
    localparam logic [15:0] GEN_OR_SELECT_IDX  = 16'h9dda;
    localparam logic [15:0] GEN_AND_SELECT_IDX = 16'h9dee;
    localparam logic [15:0] CH_OR_AVAIL_LO_IDX = 16'h9e02;
    localparam logic [15:0] CH_OR_AVAIL_HI_IDX = 16'h9e03;
    localparam logic [15:0] CH_OR_SEL_LO_IDX   = 16'h9e0c;
    localparam logic [15:0] CH_OR_SEL_HI_IDX   = 16'h9e0d;
    localparam logic [15:0] CH_AND_SEL_LO_IDX  = 16'h9e20;
    localparam logic [15:0] CH_AND_SEL_HI_IDX  = 16'h9e21;
    localparam logic [15:0] CONTROL_IDX        = 16'h9e40;
    localparam logic [15:0] DELAY_IDX          = 16'h9e41;
    localparam logic [15:0] STATUS_IDX         = 16'h9e42;

    // ========================================================
    // General mask source bits
    localparam logic [31:0] NO_SOURCE      = 32'h0000_0000;
    localparam logic [31:0] SOFT_SOURCE    = 32'h0000_0001;
    localparam int          SOFT_POS       = 0;
    localparam int          EXT0_POS       = 1;
    localparam int          EXT1_POS       = 2;
    localparam int          XTTL0_POS      = 8;
    localparam int          XTTL1_POS      = 9;
    localparam logic [31:0] GEN_OR_RESET   = SOFT_SOURCE;
    localparam logic [31:0] GEN_AND_RESET  = NO_SOURCE;
    localparam logic [31:0] CH_MASK_RESET  = 32'h0000_0000;
    localparam logic [31:0] DELAY_RESET    = 32'h0000_0000;

    // ========================================================
    // Control and status bits
    localparam int CTL_ENABLE_POS = 0;
    localparam int CTL_START_POS  = 1;
    localparam int CTL_FORCE_POS  = 2;
    localparam int CTL_STOP_POS   = 3;
    localparam int ST_WAIT_POS    = 0;
    localparam int ST_DELAY_POS   = 1;
    localparam int ST_FIRED_POS   = 2;

    localparam int NUM_PINS = 4;

    typedef enum logic [1:0] {
        TOM_IDLE  = 2'b00,
        TOM_WAIT  = 2'b01,
        TOM_DELAY = 2'b10
    } tom_state_t;

endpackage

//--- verification/tom_trigger_sva.sv
// Assertion checker for the trigger OR mask engine
`timescale 1ns/10ps
`default_nettype none

module tom_trigger_sva #(
    parameter bit ACQUISITION  = 1'b1,
    parameter bit DIGITAL      = 1'b0,
    parameter bit HAS_EXT1     = 1'b0,
    parameter bit HAS_EXTRA_IO = 1'b0,
    parameter int NUM_CHANNELS = 64
) (
    input wire logic        clk_sys_in,
    input wire logic        reset_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_rd_in,
    input wire logic [63:0] channel_trig_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic        trigger_out,
    input wire logic        or_hit_out,
    input wire logic        waiting_out
);
    // ====================================================
    // Mirrors of the written registers
    localparam logic [31:0] GEN_AV = {22'h0, HAS_EXTRA_IO, HAS_EXTRA_IO,
        5'h0, DIGITAL & HAS_EXT1, 2'b11};
    localparam logic [63:0] CH_AV = !ACQUISITION ? 64'h0 :
        (NUM_CHANNELS >= 64) ? '1 : (64'h1 << NUM_CHANNELS) - 64'h1;
    logic [31:0] gen_q;
    logic [31:0] ch_lo;
    logic [31:0] dly_q;
    logic        en_q;
    logic        wr_ctl;
    assign wr_ctl = reg_wr_in && reg_addr_in == tom_pkg::CONTROL_IDX;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            gen_q <= tom_pkg::GEN_OR_RESET;
            ch_lo <= 32'h0;
            dly_q <= 32'h0;
            en_q <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == tom_pkg::GEN_OR_SELECT_IDX)
                gen_q <= reg_wdata_in & GEN_AV;
            if (reg_addr_in == tom_pkg::CH_OR_SEL_LO_IDX)
                ch_lo <= reg_wdata_in & CH_AV[31:0];
            if (reg_addr_in == tom_pkg::DELAY_IDX)
                dly_q <= reg_wdata_in;
            if (wr_ctl)
                en_q <= reg_wdata_in[tom_pkg::CTL_ENABLE_POS];
        end
    end

    // ====================================================
    // Properties
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read got no data valid");
    rd_quiet_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("data valid without a read");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (reg_rd_in && reg_addr_in == 16'h0 |=>
        reg_rdata_out == 32'h0) else $error("unmapped read not zero");
    gen_avail_a: assert property (reg_rd_in &&
        reg_addr_in == tom_pkg::GEN_OR_AVAIL_IDX |=> reg_rdata_out == GEN_AV)
        else $error("general availability wrong");
    gen_select_a: assert property (reg_rd_in &&
        reg_addr_in == tom_pkg::GEN_OR_SELECT_IDX |=>
        reg_rdata_out == $past(gen_q)) else $error("general mask readback wrong");
    chan_low_a: assert property (reg_rd_in &&
        reg_addr_in == tom_pkg::CH_OR_SEL_LO_IDX |=>
        reg_rdata_out == $past(ch_lo)) else $error("channel mask readback wrong");
    enable_gate_a: assert property (!en_q && !$past(en_q) |-> !or_hit_out)
        else $error("mask hit while disabled");
    chan_hit_a: assert property ($past(en_q &&
        (channel_trig_in[31:0] & ch_lo) != 32'h0) |-> or_hit_out)
        else $error("enabled channel missed");
    force_trig_a: assert property (wr_ctl && waiting_out && dly_q == 32'h0 &&
        reg_wdata_in[tom_pkg::CTL_FORCE_POS] &&
        !reg_wdata_in[tom_pkg::CTL_STOP_POS] |-> ##[1:4] trigger_out)
        else $error("force gave no trigger");
    trig_pulse_a: assert property (trigger_out |=> !trigger_out)
        else $error("trigger longer than one cycle");

    cover property (trigger_out);
    cover property (or_hit_out && waiting_out);
    cover property (reg_rvalid_out && reg_rdata_out == GEN_AV);
endmodule

bind tom_trigger_engine tom_trigger_sva #(
    .ACQUISITION(ACQUISITION), .DIGITAL(DIGITAL), .HAS_EXT1(HAS_EXT1),
    .HAS_EXTRA_IO(HAS_EXTRA_IO), .NUM_CHANNELS(NUM_CHANNELS)
) u_sva (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .channel_trig_in(channel_trig_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .trigger_out(trigger_out), .or_hit_out(or_hit_out),
    .waiting_out(waiting_out)
);
`default_nettype wire

//--- verification/tom_ttl_model.sv
// Behavioural model of the external TTL trigger sources
`timescale 1ns/10ps
`default_nettype none

module tom_ttl_model (
    input  wire logic       clk_in,
    input  wire logic       slow_in,
    input  wire logic [3:0] level_in,
    output logic      [3:0] pins_out
);
    // ====================================================
    // Sources settle one or four clocks after the request
    logic [3:0] stage [0:3];
    always_ff @(posedge clk_in) begin
        stage[0] <= level_in;
        for (int i = 1; i < 4; i++) begin
            stage[i] <= stage[i-1];
        end
    end
    // Presents only an already detected condition
    assign pins_out = slow_in ? stage[3] : stage[0];
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking testbench for the trigger OR mask engine
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        clk_sys_in, reset_in, reg_wr_in, reg_rd_in, slow;
    logic [15:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [63:0] channel_trig_in;
    logic [3:0]  lvl, pins;
    logic        reg_rvalid_out, trigger_out, or_hit_out, waiting_out;
    int          err_total, tests_run, n0, n1;
    localparam logic [31:0] GEN_AV = 32'h0000_0307;
    localparam int SRC [4] = '{tom_pkg::EXT0_POS, tom_pkg::EXT1_POS,
        tom_pkg::XTTL0_POS, tom_pkg::XTTL1_POS};
    localparam int BAD [2] = '{1, 32};
    localparam int GOOD [2] = '{0, 33};

    tom_trigger_engine #(.DIGITAL(1'b1), .HAS_EXT1(1'b1),
        .HAS_EXTRA_IO(1'b1)) u_dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
        .ext_trigger_in0(pins[0]), .ext_trigger_in1(pins[1]),
        .extra_trigger_in0(pins[2]), .extra_trigger_in1(pins[3]),
        .channel_trig_in(channel_trig_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .trigger_out(trigger_out),
        .or_hit_out(or_hit_out), .waiting_out(waiting_out));
    tom_ttl_model u_src (.clk_in(clk_sys_in), .slow_in(slow),
        .level_in(lvl), .pins_out(pins));

    // ====================================================
    // Access and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys_in) #2;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge clk_sys_in) #2;
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in) #2;
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(posedge clk_sys_in) #2;
        reg_rd_in = 1'b0;
        chk({31'h0, reg_rvalid_out}, 32'h1);
        chk(reg_rdata_out, exp);
    endtask
    // Stop first, so a leftover trigger cannot leak into the next case
    task automatic arm(input logic [31:0] gen, input logic [31:0] ctl);
        wr(tom_pkg::CONTROL_IDX, 32'h8);
        wr(tom_pkg::GEN_OR_SELECT_IDX, gen);
        wr(tom_pkg::CONTROL_IDX, ctl);
    endtask
    task automatic wait_trig(input int lim, output int n);
        n = -1;
        for (int i = 1; i <= lim && n < 0; i++) begin
            @(posedge clk_sys_in) #2;
            if (trigger_out === 1'b1) n = i;
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ====================================================
    // Clock, watchdog and test sequence
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #500000;
        err_total++;
        end_sim();
    end
    initial begin
        {reset_in, reg_wr_in, reg_rd_in, slow} = 4'b1000;
        {reg_addr_in, reg_wdata_in, channel_trig_in, lvl} = '0;
        err_total = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_sys_in);
        #2 reset_in = 1'b0;
        rd(tom_pkg::GEN_OR_SELECT_IDX, tom_pkg::SOFT_SOURCE);
        rd(tom_pkg::GEN_OR_AVAIL_IDX, GEN_AV);
        wr(tom_pkg::CH_OR_AVAIL_LO_IDX, 32'h0);
        rd(tom_pkg::CH_OR_AVAIL_LO_IDX, 32'hffff_ffff);
        rd(tom_pkg::CH_OR_AVAIL_HI_IDX, 32'hffff_ffff);
        rd(tom_pkg::CH_OR_SEL_HI_IDX, 32'h0);
        rd(16'h0000, 32'h0);
        wr(tom_pkg::GEN_OR_SELECT_IDX, 32'hffff_ffff);
        rd(tom_pkg::GEN_OR_SELECT_IDX, GEN_AV);
        wr(tom_pkg::CH_OR_SEL_LO_IDX, 32'ha5a5_a5a5);
        wr(tom_pkg::CH_OR_SEL_HI_IDX, 32'h5a5a_5a5a);
        rd(tom_pkg::CH_OR_SEL_LO_IDX, 32'ha5a5_a5a5);
        rd(tom_pkg::CH_OR_SEL_HI_IDX, 32'h5a5a_5a5a);
        arm(tom_pkg::SOFT_SOURCE, 32'h3);
        wait_trig(20, n0);
        chk({31'h0, n0 >= 0}, 32'h1);
        wr(tom_pkg::DELAY_IDX, 32'h5);
        arm(tom_pkg::SOFT_SOURCE, 32'h3);
        wait_trig(30, n1);
        chk(32'(n1 - n0), 32'h5);
        // Zero delay so the force check in the checker is reached
        wr(tom_pkg::DELAY_IDX, 32'h0);
        arm(tom_pkg::SOFT_SOURCE, 32'h2);
        wait_trig(20, n0);
        chk(32'(n0), 32'hffff_ffff);
        chk({31'h0, waiting_out}, 32'h1);
        wr(tom_pkg::CONTROL_IDX, 32'h4);
        wait_trig(20, n0);
        chk({31'h0, n0 >= 0}, 32'h1);
        wr(tom_pkg::CONTROL_IDX, 32'h4);
        wait_trig(20, n0);
        chk(32'(n0), 32'hffff_ffff);
        arm(tom_pkg::NO_SOURCE, 32'h3);
        wait_trig(20, n0);
        chk(32'(n0), 32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            arm(32'h1 << SRC[i], 32'h3);
            slow = i[0];
            lvl = 4'h1 << ((i + 1) % 4);
            wait_trig(15, n0);
            chk(32'(n0), 32'hffff_ffff);
            lvl = 4'h1 << i;
            wait_trig(15, n0);
            chk({31'h0, n0 >= 0}, 32'h1);
            lvl = 4'h0;
        end
        for (int j = 0; j < 2; j++) begin
            arm(tom_pkg::NO_SOURCE, 32'h3);
            channel_trig_in = 64'h1 << BAD[j];
            wait_trig(10, n0);
            chk(32'(n0), 32'hffff_ffff);
            chk({31'h0, or_hit_out}, 32'h0);
            channel_trig_in = 64'h1 << GOOD[j];
            wait_trig(10, n0);
            chk({31'h0, n0 >= 0}, 32'h1);
            chk({31'h0, or_hit_out}, 32'h1);
            channel_trig_in = 64'h0;
        end
        end_sim();
    end
endmodule
`default_nettype wire
